// >>> common/fpab_pkg.sv
package fpab_pkg;

    localparam int XLEN  = 64;
    localparam int NREG  = 32;
    localparam int RIDX  = 5;

    // instruction field values
    localparam logic [5:0] OPC_FLOAT_COP = 6'h11;
    localparam logic [5:0] FN_ADD        = 6'h00;
    localparam logic [5:0] FN_MAG        = 6'h05;
    localparam logic [4:0] RS_BRANCH     = 5'h08;
    localparam logic [4:0] RT_BR_FALSE   = 5'h00;
    localparam logic [4:0] RT_BR_TRUE    = 5'h01;
    localparam logic [4:0] RT_ZERO       = 5'h00;
    localparam logic [4:0] FMT_SINGLE    = 5'h10;
    localparam logic [4:0] FMT_DOUBLE    = 5'h11;
    localparam int         OFS_W         = 16;
    localparam int         OFS_SHIFT     = 2;

    // operand formats
    localparam int S_EW = 8;
    localparam int S_FW = 23;
    localparam int D_EW = 11;
    localparam int D_FW = 52;

    // control/status register layout
    localparam int          COND_BIT   = 23;
    localparam int          RM_LSB     = 0;
    localparam int          FLAG_LSB   = 2;
    localparam int          EN_LSB     = 7;
    localparam int          CAUSE_LSB  = 12;
    localparam logic [31:0] FCSR_RESET = 32'h0000_0000;

    // rounding modes
    localparam logic [1:0] RM_NEAR  = 2'h0;
    localparam logic [1:0] RM_ZERO  = 2'h1;
    localparam logic [1:0] RM_PLUS  = 2'h2;
    localparam logic [1:0] RM_MINUS = 2'h3;

    // positions inside the 6-bit cause vector
    localparam int C_INEXACT = 0;
    localparam int C_UNDER   = 1;
    localparam int C_OVER    = 2;
    localparam int C_INVALID = 4;
    localparam int C_UNIMPL  = 5;

    typedef enum logic [1:0] {
        EXC_NONE = 2'h0,
        EXC_CPU  = 2'h1,
        EXC_RI   = 2'h2,
        EXC_FPE  = 2'h3
    } fpab_exc_t;

    function automatic logic [XLEN-1:0] fpab_sext32(input logic [31:0] v);
        return {{(XLEN-32){v[31]}}, v};
    endfunction

endpackage

// >>> rtl/fpab_regfile.sv
`timescale 1ns/10ps
module fpab_regfile
    import fpab_pkg::*;
#(
    parameter int NR = NREG,
    parameter int W  = XLEN
) (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_n_i,
    input  wire logic [$clog2(NR)-1:0] ra_i,
    input  wire logic [$clog2(NR)-1:0] rb_i,
    output logic      [W-1:0]          ra_data_o,
    output logic      [W-1:0]          rb_data_o,
    input  wire logic                  we_i,
    input  wire logic [$clog2(NR)-1:0] wa_i,
    input  wire logic [W-1:0]          wd_i
);
    logic [W-1:0] mem [NR];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NR; i++) begin
                mem[i] <= '0;
            end
        end else if (we_i) begin
            mem[wa_i] <= wd_i;
        end
    end

    assign ra_data_o = mem[ra_i];
    assign rb_data_o = mem[rb_i];
endmodule

// >>> rtl/fpab_adder.sv
`timescale 1ns/10ps
module fpab_adder
    import fpab_pkg::*;
#(
    parameter int EW = S_EW,
    parameter int FW = S_FW
) (
    input  wire logic [EW+FW:0] a_i,
    input  wire logic [EW+FW:0] b_i,
    input  wire logic [1:0]     rm_i,
    output logic      [EW+FW:0] sum_o,
    output logic      [5:0]     cause_o
);
    localparam int MW = FW + 4;
    localparam logic [EW-1:0] EMAX = '1;

    function automatic logic f_nan(input logic [EW+FW:0] v);
        return (&v[EW+FW-1:FW]) && (|v[FW-1:0]);
    endfunction
    function automatic logic f_inf(input logic [EW+FW:0] v);
        return (&v[EW+FW-1:FW]) && !(|v[FW-1:0]);
    endfunction
    function automatic logic f_den(input logic [EW+FW:0] v);
        return !(|v[EW+FW-1:FW]) && (|v[FW-1:0]);
    endfunction

    logic [EW+FW:0]   big;
    logic [EW+FW:0]   sml;
    logic [MW:0]      mb;
    logic [MW:0]      ms;
    logic [MW:0]      msum;
    logic [MW-1:0]    norm;
    logic [FW+1:0]    rnd;
    logic signed [EW+1:0] ex;
    logic             sb;
    logic             eff_sub;
    logic             stk;
    logic             inex;
    logic             up;
    logic             to_inf;
    int               sh;
    int               lz;

    always_comb begin
        big = a_i;
        sml = b_i;
        if (b_i[EW+FW-1:0] > a_i[EW+FW-1:0]) begin
            big = b_i;
            sml = a_i;
        end
        sb      = big[EW+FW];
        eff_sub = big[EW+FW] ^ sml[EW+FW];
        mb = {1'b0, |big[EW+FW-1:FW], big[FW-1:0], 3'b000};
        ms = {1'b0, |sml[EW+FW-1:FW], sml[FW-1:0], 3'b000};
        sh = int'(big[EW+FW-1:FW]) - int'(sml[EW+FW-1:FW]);
        // bits shifted out fold into the sticky bit
        stk = 1'b0;
        for (int i = 0; i <= MW; i++) begin
            if (i < sh) begin
                stk = stk | ms[i];
            end
        end
        ms    = (sh > MW) ? '0 : (ms >> sh);
        ms[0] = ms[0] | stk;
        msum  = eff_sub ? (mb - ms) : (mb + ms);
        ex    = (EW+2)'(big[EW+FW-1:FW]);
        lz    = 0;
        if (msum[MW]) begin
            norm = {msum[MW:2], msum[1] | msum[0]};
            ex   = ex + (EW+2)'(1);
        end else begin
            for (int i = 0; i < MW; i++) begin
                if (msum[i]) begin
                    lz = MW - 1 - i;
                end
            end
            norm = msum[MW-1:0] << lz;
            ex   = ex - (EW+2)'(lz);
        end
        inex = |norm[2:0];
        unique case (rm_i)
            RM_NEAR:  up = norm[2] & (norm[3] | (|norm[1:0]));
            RM_ZERO:  up = 1'b0;
            RM_PLUS:  up = !sb & inex;
            RM_MINUS: up = sb & inex;
        endcase
        rnd = {1'b0, norm[MW-1:3]} + (FW+2)'(up);
        if (rnd[FW+1]) begin
            rnd = rnd >> 1;
            ex  = ex + (EW+2)'(1);
        end
        to_inf = (rm_i == RM_NEAR) || (rm_i == RM_PLUS && !sb) ||
                 (rm_i == RM_MINUS && sb);
        cause_o = '0;
        if (f_nan(a_i) || f_nan(b_i) ||
            (f_inf(a_i) && f_inf(b_i) && eff_sub)) begin
            sum_o = {1'b0, EMAX, {FW{1'b1}}};
            cause_o[C_INVALID] = 1'b1;
        end else if (f_den(a_i) || f_den(b_i)) begin
            // no denormal datapath: software emulates
            sum_o = '0;
            cause_o[C_UNIMPL] = 1'b1;
        end else if (f_inf(big)) begin
            sum_o = big;
        end else if (msum == '0) begin
            sum_o = {eff_sub ? (rm_i == RM_MINUS) : sb, {(EW+FW){1'b0}}};
        end else if (ex <= 0) begin
            // tiny results flush to zero
            sum_o = {sb, {(EW+FW){1'b0}}};
            cause_o[C_UNDER]   = 1'b1;
            cause_o[C_INEXACT] = 1'b1;
        end else if (ex >= (EW+2)'(EMAX)) begin
            sum_o = to_inf ? {sb, EMAX, {FW{1'b0}}}
                           : {sb, EMAX - EW'(1), {FW{1'b1}}};
            cause_o[C_OVER]    = 1'b1;
            cause_o[C_INEXACT] = 1'b1;
        end else begin
            sum_o = {sb, ex[EW-1:0], rnd[FW-1:0]};
            cause_o[C_INEXACT] = inex;
        end
    end
endmodule

// >>> rtl/fpab_exec.sv
`timescale 1ns/10ps
module fpab_exec
    import fpab_pkg::*;
(
    input  wire logic            mclk_i,
    input  wire logic            rst_n_i,
    input  wire logic            issue_valid_i,
    input  wire logic [31:0]     instr_i,
    input  wire logic [XLEN-1:0] delay_pc_i,
    input  wire logic            cop_usable_i,
    input  wire logic            fcsr_wr_i,
    input  wire logic [31:0]     fcsr_wdata_i,
    input  wire logic            cmp_valid_i,
    input  wire logic            cmp_true_i,
    input  wire logic            cmp_trap_i,
    output logic [31:0]          fcsr_o,
    output logic                 pc_load_o,
    output logic [XLEN-1:0]      pc_target_o,
    output logic                 wb_valid_o,
    output logic [RIDX-1:0]      wb_reg_o,
    output logic [XLEN-1:0]      wb_data_o,
    output logic                 exc_valid_o,
    output fpab_exc_t            exc_code_o
);
    logic [31:0]     fp_control_status_reg;
    logic [31:0]     next_fcsr;
    logic [5:0]      opcode;
    logic [4:0]      fmt;
    logic [4:0]      rt;
    logic [5:0]      funct;
    logic [4:0]      first_source_reg;
    logic [4:0]      second_source_reg;
    logic [4:0]      dest_reg;
    logic [OFS_W-1:0] offset;
    logic            is_cop;
    logic            fp_branch_class;
    logic            fp_branch_on_false;
    logic            fp_branch_on_true;
    logic            fp_magnitude_op;
    logic            fp_add_op;
    logic            arith;
    logic            fmt_ok;
    logic            is_dbl;
    logic            cond;
    logic            take_now;
    logic [XLEN-1:0] br_disp;
    logic [XLEN-1:0] br_target;
    logic [XLEN-1:0] op_a;
    logic [XLEN-1:0] op_b;
    logic [31:0]     sum_s;
    logic [XLEN-1:0] sum_d;
    logic [5:0]      cause_s;
    logic [5:0]      cause_d;
    logic            op_nan;
    logic [XLEN-1:0] mag_res;
    logic [XLEN-1:0] result;
    logic [5:0]      cause;
    logic            trap;
    fpab_exc_t       exc;
    logic            arith_go;
    logic            wr_en;

    // instruction fields
    assign opcode            = instr_i[31:26];
    assign fmt               = instr_i[25:21];
    assign rt                = instr_i[20:16];
    assign second_source_reg = instr_i[20:16];
    assign first_source_reg  = instr_i[15:11];
    assign dest_reg          = instr_i[10:6];
    assign funct             = instr_i[5:0];
    assign offset            = instr_i[OFS_W-1:0];

    assign is_cop          = opcode == OPC_FLOAT_COP;
    assign fp_branch_class = is_cop && fmt == RS_BRANCH;
    assign fp_branch_on_false = fp_branch_class && rt == RT_BR_FALSE;
    assign fp_branch_on_true  = fp_branch_class && rt == RT_BR_TRUE;
    // rs values below the format range belong to other units
    assign fp_magnitude_op = is_cop && fmt[4] && funct == FN_MAG &&
                             rt == RT_ZERO;
    assign fp_add_op       = is_cop && fmt[4] && funct == FN_ADD;
    assign arith           = fp_magnitude_op || fp_add_op;
    assign fmt_ok          = fmt == FMT_SINGLE || fmt == FMT_DOUBLE;
    assign is_dbl          = fmt == FMT_DOUBLE;

    // branch condition and target
    assign cond      = fp_control_status_reg[COND_BIT];
    assign take_now  = issue_valid_i && cop_usable_i &&
                       ((fp_branch_on_false && !cond) ||
                        (fp_branch_on_true && cond));
    assign br_disp   = {{(XLEN-OFS_W-OFS_SHIFT){offset[OFS_W-1]}},
                        offset, {OFS_SHIFT{1'b0}}};
    assign br_target = delay_pc_i + br_disp;

    // odd double registers are not policed; software keeps them legal
    fpab_regfile #(
        .NR (NREG),
        .W  (XLEN)
    ) u_regs (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .ra_i      (first_source_reg),
        .rb_i      (second_source_reg),
        .ra_data_o (op_a),
        .rb_data_o (op_b),
        .we_i      (wr_en),
        .wa_i      (dest_reg),
        .wd_i      (result)
    );

    fpab_adder #(
        .EW (S_EW),
        .FW (S_FW)
    ) u_add_s (
        .a_i     (op_a[31:0]),
        .b_i     (op_b[31:0]),
        .rm_i    (fp_control_status_reg[RM_LSB +: 2]),
        .sum_o   (sum_s),
        .cause_o (cause_s)
    );

    fpab_adder #(
        .EW (D_EW),
        .FW (D_FW)
    ) u_add_d (
        .a_i     (op_a),
        .b_i     (op_b),
        .rm_i    (fp_control_status_reg[RM_LSB +: 2]),
        .sum_o   (sum_d),
        .cause_o (cause_d)
    );

    // magnitude path: arithmetic, so NaN is not passed through
    always_comb begin
        if (is_dbl) begin
            op_nan  = (&op_a[D_EW+D_FW-1:D_FW]) && (|op_a[D_FW-1:0]);
            mag_res = op_nan ? {1'b0, {D_EW{1'b1}}, {D_FW{1'b1}}}
                             : {1'b0, op_a[D_EW+D_FW-1:0]};
        end else begin
            op_nan  = (&op_a[S_EW+S_FW-1:S_FW]) && (|op_a[S_FW-1:0]);
            mag_res = fpab_sext32(op_nan ?
                        {1'b0, {S_EW{1'b1}}, {S_FW{1'b1}}} :
                        {1'b0, op_a[S_EW+S_FW-1:0]});
        end
    end

    always_comb begin
        cause  = '0;
        result = mag_res;
        if (fp_magnitude_op) begin
            cause[C_INVALID] = op_nan;
        end else if (is_dbl) begin
            cause  = cause_d;
            result = sum_d;
        end else begin
            cause  = cause_s;
            result = fpab_sext32(sum_s);
        end
    end

    // unimplemented always traps; others trap only when enabled
    assign trap = cause[C_UNIMPL] ||
                  (|(cause[4:0] & fp_control_status_reg[EN_LSB +: 5]));

    // exception priority: unusable, reserved, arithmetic
    always_comb begin
        exc = EXC_NONE;
        if (issue_valid_i && (fp_branch_class || arith)) begin
            if (!cop_usable_i) begin
                exc = EXC_CPU;
            end else if (fp_branch_class) begin
                if (!fp_branch_on_false && !fp_branch_on_true) begin
                    exc = EXC_RI;
                end
            end else if (!fmt_ok) begin
                exc = EXC_RI;
            end else if (trap) begin
                exc = EXC_FPE;
            end
        end
    end

    assign arith_go = issue_valid_i && cop_usable_i && arith && fmt_ok;
    assign wr_en    = arith_go && !trap;

    // later terms win: hardware updates override a same-cycle write
    always_comb begin
        next_fcsr = fp_control_status_reg;
        if (fcsr_wr_i) begin
            next_fcsr = fcsr_wdata_i;
        end
        if (arith_go) begin
            next_fcsr[CAUSE_LSB +: 6] = cause;
            if (!trap) begin
                next_fcsr[FLAG_LSB +: 5] = next_fcsr[FLAG_LSB +: 5] |
                                           cause[4:0];
            end
        end
        if (cmp_valid_i && !cmp_trap_i) begin
            next_fcsr[COND_BIT] = cmp_true_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fp_control_status_reg <= FCSR_RESET;
        end else begin
            fp_control_status_reg <= next_fcsr;
        end
    end

    // target loads one step later; the delay slot is never squashed
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_load_o   <= 1'b0;
            pc_target_o <= '0;
        end else begin
            pc_load_o   <= take_now;
            if (take_now) begin
                pc_target_o <= br_target;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_valid_o <= 1'b0;
            wb_reg_o   <= '0;
            wb_data_o  <= '0;
        end else begin
            wb_valid_o <= wr_en;
            if (wr_en) begin
                wb_reg_o  <= dest_reg;
                wb_data_o <= result;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exc_valid_o <= 1'b0;
            exc_code_o  <= EXC_NONE;
        end else begin
            exc_valid_o <= exc != EXC_NONE;
            exc_code_o  <= exc;
        end
    end

    assign fcsr_o = fp_control_status_reg;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_issue(logic c);
        issue_valid_i && cop_usable_i && c;
    endsequence
    sequence s_load(logic [XLEN-1:0] t);
        pc_load_o && pc_target_o == t;
    endsequence
    property p_br_false_take;
        logic [XLEN-1:0] t;
        (s_issue(fp_branch_on_false && !cond),
         t = delay_pc_i + {{46{offset[15]}}, offset, 2'b00}) |=> s_load(t);
    endproperty
    a_br_false_take: assert property (p_br_false_take)
        else $error("false branch did not load target");
    property p_br_true_take;
        logic [XLEN-1:0] t;
        (s_issue(fp_branch_on_true && cond),
         t = delay_pc_i + {{46{offset[15]}}, offset, 2'b00}) |=> s_load(t);
    endproperty
    a_br_true_take: assert property (p_br_true_take)
        else $error("true branch did not load target");
    property p_no_take;
        !take_now |=> !pc_load_o;
    endproperty
    a_no_take: assert property (p_no_take)
        else $error("pc loaded without taken branch");
    property p_br_exc;
        s_issue(fp_branch_class) |=> exc_code_o != EXC_FPE;
    endproperty
    a_br_exc: assert property (p_br_exc)
        else $error("branch raised arithmetic exception");
    property p_abs_mag;
        s_issue(fp_magnitude_op && fmt_ok && !is_dbl && !op_nan)
            |=> wb_valid_o && wb_data_o[31:0] == {1'b0, $past(op_a[30:0])};
    endproperty
    a_abs_mag: assert property (p_abs_mag)
        else $error("magnitude result wrong");
    property p_abs_nan;
        s_issue(fp_magnitude_op && fmt_ok && op_nan)
            |=> fcsr_o[CAUSE_LSB + C_INVALID];
    endproperty
    a_abs_nan: assert property (p_abs_nan)
        else $error("NaN magnitude did not flag invalid");
    property p_sext;
        wb_valid_o && !$past(is_dbl)
            |-> wb_data_o[63:31] == {33{wb_data_o[31]}};
    endproperty
    a_sext: assert property (p_sext)
        else $error("single result not sign-extended");
    property p_cmp;
        cmp_valid_i && !cmp_trap_i |=> fcsr_o[COND_BIT] == $past(cmp_true_i);
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("compare did not set condition bit");
    property p_cond_hold;
        !cmp_valid_i && !fcsr_wr_i |=> $stable(fcsr_o[COND_BIT]);
    endproperty
    a_cond_hold: assert property (p_cond_hold)
        else $error("condition bit changed without compare");
    property p_ri_fmt;
        s_issue(arith && !fmt_ok) |=> exc_valid_o && exc_code_o == EXC_RI
            && !wb_valid_o;
    endproperty
    a_ri_fmt: assert property (p_ri_fmt)
        else $error("bad format not reserved");
    property p_add_trap;
        s_issue(fp_add_op && fmt_ok && trap)
            |=> exc_code_o == EXC_FPE && !wb_valid_o;
    endproperty
    a_add_trap: assert property (p_add_trap)
        else $error("trapping add wrote a result");
endmodule

// >>> verif/fpab_pipe_model.sv
`timescale 1ns/10ps
module fpab_pipe_model
    import fpab_pkg::*;
(
    input  wire logic            mclk_i,
    output logic                 issue_valid_o,
    output logic [31:0]          instr_o,
    output logic [XLEN-1:0]      delay_pc_o
);
    initial begin
        issue_valid_o = 1'b0;
        instr_o       = 32'h0000_0000;
        delay_pc_o    = '0;
    end
    // one or two words, back to back; released lines show the inverse
    task automatic issue(input logic [31:0] w0, input logic [31:0] w1,
                         input logic [XLEN-1:0] pc, input bit two);
        @(posedge mclk_i);
        #1;
        issue_valid_o = 1'b1;
        instr_o       = w0;
        delay_pc_o    = pc;
        @(posedge mclk_i);
        #1;
        if (two) begin
            instr_o    = w1;
            delay_pc_o = pc + 64'h4;
            @(posedge mclk_i);
            #1;
        end
        issue_valid_o = 1'b0;
        instr_o       = ~instr_o;
        delay_pc_o    = ~delay_pc_o;
    endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import fpab_pkg::*;
;
    logic            mclk_i, rst_n_i, cop_usable_i, fcsr_wr_i;
    logic [31:0]     fcsr_wdata_i, instr_i, fcsr_o, seed;
    logic            cmp_valid_i, cmp_true_i, cmp_trap_i, issue_valid_i;
    logic [XLEN-1:0] delay_pc_i, pc_target_o, wb_data_o, pc, tgt;
    logic            pc_load_o, wb_valid_o, exc_valid_o, cond, taken;
    logic [RIDX-1:0] wb_reg_o, fd;
    logic [15:0]     off;
    fpab_exc_t       exc_code_o;
    int              fails, checks_done;

    fpab_exec i_fpab_exec (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .issue_valid_i(issue_valid_i), .instr_i(instr_i),
        .delay_pc_i(delay_pc_i), .cop_usable_i(cop_usable_i),
        .fcsr_wr_i(fcsr_wr_i), .fcsr_wdata_i(fcsr_wdata_i),
        .cmp_valid_i(cmp_valid_i), .cmp_true_i(cmp_true_i),
        .cmp_trap_i(cmp_trap_i), .fcsr_o(fcsr_o), .pc_load_o(pc_load_o),
        .pc_target_o(pc_target_o), .wb_valid_o(wb_valid_o),
        .wb_reg_o(wb_reg_o), .wb_data_o(wb_data_o),
        .exc_valid_o(exc_valid_o), .exc_code_o(exc_code_o));
    fpab_pipe_model i_fpab_pipe_model (.mclk_i(mclk_i),
        .issue_valid_o(issue_valid_i), .instr_o(instr_i),
        .delay_pc_o(delay_pc_i));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] br(logic [4:0] rt, logic [15:0] o);
        return {OPC_FLOAT_COP, RS_BRANCH, rt, o};
    endfunction
    function automatic logic [63:0] exp_tgt(logic [63:0] p, logic [15:0] o);
        return p + {{46{o[15]}}, o, 2'b00};
    endfunction
    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        chk_val({63'h0, got}, {63'h0, exp});
    endtask
    task automatic resp(input logic wb, input logic ex, input logic [1:0] c,
                        input logic pl);
        chk_flag(wb_valid_o, wb);
        chk_flag(exc_valid_o, ex);
        chk_val({62'h0, exc_code_o}, {62'h0, c});
        chk_flag(pc_load_o, pl);
    endtask
    task automatic compare(input logic t, input logic trap);
        @(posedge mclk_i);
        #1;
        cmp_valid_i = 1'b1;
        cmp_true_i  = t;
        cmp_trap_i  = trap;
        @(posedge mclk_i);
        #1;
        cmp_valid_i = 1'b0;
        cmp_true_i  = ~t;
    endtask
    task automatic final_report();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        final_report();
    end

    initial begin
        seed = 32'h0000_001a;
        {rst_n_i, fcsr_wr_i, fcsr_wdata_i, cmp_valid_i} = '0;
        {cmp_true_i, cmp_trap_i, fails, checks_done} = '0;
        cop_usable_i = 1'b1;
        repeat (8) @(posedge mclk_i);
        #1;
        rst_n_i = 1'b1;
        chk_val({32'h0, fcsr_o}, {32'h0, FCSR_RESET});
        resp(1'b0, 1'b0, 2'h0, 1'b0);
        // branches on random conditions, offset extremes first
        for (int i = 0; i < 12; i++) begin
            cond = 1'(rnd());
            compare(cond, 1'b0);
            compare(~cond, 1'b1);
            chk_flag(fcsr_o[23], cond);
            off = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : 16'(rnd());
            pc = {rnd(), rnd()};
            taken = (cond == i[0]);
            i_fpab_pipe_model.issue(br({4'h0, i[0]}, off), 0, pc, 0);
            resp(1'b0, 1'b0, 2'h0, taken);
            if (taken)
                chk_val(pc_target_o, exp_tgt(pc, off));
        end
        // taken branch with an add in its delay slot
        compare(1'b1, 1'b0);
        pc = {rnd(), rnd()};
        tgt = exp_tgt(pc, 16'hfffe);
        i_fpab_pipe_model.issue(br(RT_BR_TRUE, 16'hfffe),
            {OPC_FLOAT_COP, FMT_SINGLE, 15'h0843, FN_ADD}, pc, 1);
        chk_flag(wb_valid_o, 1'b1);
        chk_val(pc_target_o, tgt);
        // undefined branch kinds and unusable unit
        for (int k = 0; k < 3; k++) begin
            i_fpab_pipe_model.issue(br((k == 2) ? 5'h1f : 5'(k + 2),
                16'(rnd())), 0, 0, 0);
            resp(1'b0, 1'b1, EXC_RI, 1'b0);
        end
        cop_usable_i = 1'b0;
        i_fpab_pipe_model.issue(br(RT_BR_TRUE, 16'h0010), 0, 0, 0);
        resp(1'b0, 1'b1, EXC_CPU, 1'b0);
        cop_usable_i = 1'b1;
        // arithmetic over every mode, format and function
        for (int m = 0; m < 16; m++) begin
            @(posedge mclk_i);
            #1;
            fcsr_wr_i = 1'b1;
            fcsr_wdata_i = {30'h0, m[1:0]};
            @(posedge mclk_i);
            #1;
            fcsr_wr_i = 1'b0;
            chk_val({62'h0, fcsr_o[1:0]}, {62'h0, m[1:0]});
            fd = 5'(rnd()) & (m[2] ? 5'h1e : 5'h1f);
            i_fpab_pipe_model.issue({OPC_FLOAT_COP, m[2] ? FMT_DOUBLE :
                FMT_SINGLE, m[3] ? RT_ZERO : 5'h02, 5'h04, fd,
                m[3] ? FN_MAG : FN_ADD}, 0, 0, 0);
            resp(1'b1, 1'b0, 2'h0, 1'b0);
            chk_val({59'h0, wb_reg_o}, {59'h0, fd});
            chk_val(wb_data_o, 64'h0);
        end
        i_fpab_pipe_model.issue({OPC_FLOAT_COP, 5'h14, 15'h0, FN_ADD},
            0, 0, 0);
        resp(1'b0, 1'b1, EXC_RI, 1'b0);
        final_report();
    end
endmodule
